// *** src/monitor_defs.svh ***
// Constants for the drive status and current monitor
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH

// ****
// Clock and timing
// ****
`define CLK_MHZ 250
`define AVG_PERIOD_US 10000
`define PEAK_PERIOD_US 300
`define WIN_SPAN_MS 10000
`define WIN_DEPTH 60000
`define AVG_PERIOD_CYC (`AVG_PERIOD_US * `CLK_MHZ)
`define PEAK_PERIOD_CYC (`PEAK_PERIOD_US * `CLK_MHZ)
`define WIN_PERIOD_CYC ((`WIN_SPAN_MS * `CLK_MHZ) / (`WIN_DEPTH / 1000))

// ****
// Widths
// ****
`define CUR_W 16
`define SUM_W 32
`define WORD_W 32
`define IDX_USED_BITS 24

// ****
// Drive status word bit positions
// ****
`define DRV_BIT_ENABLE 11
`define DRV_BIT_CRC 8
`define DRV_BIT_AVG 6
`define DRV_BIT_POSERR 5
`define DRV_BIT_PWM 3
`define DRV_BIT_OVERCUR 1
`define DRV_BIT_ECHO 0

// ****
// Fault code and characters
// ****
`define POS_ERR_CODE 8'h14
`define CHAR_CR 8'h0d
`define CHAR_STAR 8'h2a
`define CHAR_USCORE 8'h5f
`define CHAR_PLUS 8'h2b
`define CHAR_MINUS 8'h2d
`define CHAR_DOT 8'h2e
`define CHAR_ZERO_HI 4'h3
`define BITS_LAST 6'h28
`define NUM_LAST 6'h06
`define SUFFIX_LAST 6'h08

`endif

// *** src/monitor_pkg.sv ***
// Types shared by the drive status and current monitor
package monitor_pkg;

  // Report requests arriving from the command parser
  typedef enum logic [2:0] {
    cmd_none,
    report_average_current,
    report_instant_current,
    report_peak_current,
    report_drive_flags,
    report_indexer_flags
  } cmd_e;

  // Drive flag inputs gathered from other blocks
  typedef struct packed {
    logic enable_disabled, crc_failed, pwm_shutdown, overcurrent_shutdown, echo_off;
  } drive_flags_s;

  // Indexer flags, ordered from bit 23 down to bit 0
  typedef struct packed {
    logic homing_resolver, soft_cw_limit, soft_ccw_limit, registration_move;
    logic home_limit_found, jog_enabled, queued_registration_mode, run_seq_power_up;
    logic unconditional_pause_wait, trigger_wait, home_resolver, backup_home_limit;
    logic home_high_speed, sequence_running, timer_wait, hard_ccw_limit;
    logic hard_cw_limit, pause_wait, abs_move_negative, absolute_positioning;
    logic continuous_move_mode, commanded_negative, preset_moving, continuous_moving;
  } indexer_flags_s;

endpackage : monitor_pkg

// *** src/tick_gen.sv ***
// Periodic enable pulse generator
`timescale 1ns/1ps
`default_nettype none

module tick_gen #(
  parameter int unsigned PERIOD = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  output logic tick_out
);

  logic [31:0] cnt_q;

  // ****
  // Counter, restarts whenever run drops
  // ****
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q <= 32'h0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= run_in && (cnt_q == PERIOD - 1);
      cnt_q <= (!run_in || cnt_q == PERIOD - 1) ? 32'h0 : cnt_q + 32'h1;
    end
  end

endmodule : tick_gen

`default_nettype wire

// *** src/seq_divider.sv ***
// Unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
`default_nettype none

module seq_divider #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [WIDTH-1:0] dividend_in,
  input wire logic [WIDTH-1:0] divisor_in,
  output logic done_out,
  output logic [WIDTH-1:0] quotient_out
);

  logic [WIDTH-1:0] rem_q;
  logic [WIDTH-1:0] dsr_q;
  logic [7:0] cnt_q;
  logic busy_q;
  logic [WIDTH:0] trial;

  // Shifted remainder candidate
  assign trial = {rem_q, quotient_out[WIDTH-1]};

  // ****
  // Iteration
  // ****
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rem_q <= '0;
      dsr_q <= '0;
      quotient_out <= '0;
      cnt_q <= 8'h0;
      busy_q <= 1'b0;
      done_out <= 1'b0;
    end
    else if (start_in && !busy_q)
    begin
      rem_q <= '0;
      dsr_q <= divisor_in;
      quotient_out <= dividend_in;
      cnt_q <= 8'(WIDTH);
      busy_q <= 1'b1;
      done_out <= 1'b0;
    end
    else if (busy_q)
    begin
      rem_q <= (trial >= {1'b0, dsr_q}) ? WIDTH'(trial - {1'b0, dsr_q}) : trial[WIDTH-1:0];
      quotient_out <= {quotient_out[WIDTH-2:0], trial >= {1'b0, dsr_q}};
      cnt_q <= cnt_q - 8'h1;
      busy_q <= (cnt_q != 8'h1);
      done_out <= (cnt_q == 8'h1);
    end
    else
    begin
      done_out <= 1'b0;
    end
  end

endmodule : seq_divider

`default_nettype wire

// *** src/drive_status_current_monitor.sv ***
// Current reports and status flag words of the servo drive
`timescale 1ns/1ps
`default_nettype none
`include "monitor_defs.svh"

module drive_status_current_monitor #(
  parameter int unsigned WIN_DEPTH = `WIN_DEPTH,
  parameter int unsigned WIN_PERIOD_CYC = `WIN_PERIOD_CYC,
  parameter int unsigned AVG_PERIOD_CYC = `AVG_PERIOD_CYC,
  parameter int unsigned PEAK_PERIOD_CYC = `PEAK_PERIOD_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire monitor_pkg::cmd_e cmd_code_in,
  input wire logic char_rx_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic signed [`CUR_W-1:0] cur_sample_in,
  input wire logic [`CUR_W-1:0] avg_limit_in,
  input wire monitor_pkg::drive_flags_s drv_flags_in,
  input wire monitor_pkg::indexer_flags_s idx_flags_in,
  input wire logic signed [`WORD_W-1:0] pos_err_in,
  input wire logic [`WORD_W-1:0] max_position_error_cfg_in,
  input wire logic fault_clear_in,
  output logic amp_shutdown_out,
  output logic [7:0] error_code_out,
  output logic signed [`CUR_W-1:0] avg_current_out,
  output logic signed [`CUR_W-1:0] peak_current_out,
  output logic [`WORD_W-1:0] drive_status_word_out,
  output logic [`WORD_W-1:0] indexer_status_word_out,
  output logic report_busy_out
);

  localparam int PTR_W = $clog2(WIN_DEPTH);
  localparam logic [17*8-1:0] AVG_TXT = "*AVERAGE_CURRENT=";
  localparam logic [9*8-1:0] CUR_TXT = "*CURRENT=";
  localparam logic [8*8-1:0] SFX_TXT = "_AMPERES";

  typedef enum logic [2:0] {gen_idle, gen_prefix, gen_number, gen_suffix, gen_bits} gen_e;

  // ****
  // Declarations
  // ****
  monitor_pkg::cmd_e mode_q;
  monitor_pkg::cmd_e kind_q;
  gen_e gen_q;
  logic [5:0] idx_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic gen_valid;
  logic [7:0] gen_char;
  logic adv;
  logic line_start;
  logic [`WORD_W-1:0] word_q;
  logic neg_q;
  logic [19:0] bcd_q;
  logic signed [`CUR_W-1:0] pick_val;
  logic [`CUR_W:0] pick_mag;
  logic win_tick;
  logic avg_tick;
  logic peak_tick;
  logic [`CUR_W-1:0] mem [WIN_DEPTH];
  logic [PTR_W-1:0] ptr_q;
  logic filled_q;
  logic phase_q;
  logic signed [`CUR_W-1:0] new_q;
  logic signed [`CUR_W-1:0] old_q;
  logic signed [`SUM_W-1:0] sum_q;
  logic [`SUM_W-1:0] sum_mag;
  logic sum_neg_q;
  logic div_done;
  logic [`SUM_W-1:0] quot;
  logic [`CUR_W-1:0] avg_mag;
  logic avg_over;
  logic [`WORD_W:0] err_mag;
  logic pos_trip;
  logic [`WORD_W-1:0] drv_word;
  logic [`WORD_W-1:0] idx_word;

  // Binary to packed BCD, five digits
  function automatic logic [19:0] to_bcd(input logic [15:0] bin);
    logic [19:0] bcd;
    bcd = 20'h0;
    for (int i = 15; i >= 0; i--)
    begin
      for (int d = 0; d < 5; d++)
      begin
        if (bcd[d*4 +: 4] > 4'h4)
        begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[18:0], bin[i]};
    end
    return bcd;
  endfunction : to_bcd

  // ****
  // Rate enables
  // ****
  tick_gen #(.PERIOD(WIN_PERIOD_CYC)) u_win_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(1'b1),
    .tick_out(win_tick)
  );

  tick_gen #(.PERIOD(AVG_PERIOD_CYC)) u_avg_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(1'b1),
    .tick_out(avg_tick)
  );

  // Peak sampling clock runs only during peak reports
  tick_gen #(.PERIOD(PEAK_PERIOD_CYC)) u_peak_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(mode_q == monitor_pkg::report_peak_current && !cmd_valid_in),
    .tick_out(peak_tick)
  );

  // ****
  // Rolling current window
  // ****
  // Sample storage, read oldest then overwrite
  always_ff @(posedge clk_in)
  begin
    if (win_tick)
    begin
      old_q <= mem[ptr_q];
    end
    else if (phase_q)
    begin
      mem[ptr_q] <= new_q;
    end
  end

  // Running sum, pointer and fill state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ptr_q <= '0;
      filled_q <= 1'b0;
      phase_q <= 1'b0;
      new_q <= '0;
      sum_q <= '0;
    end
    else if (win_tick)
    begin
      new_q <= cur_sample_in;
      phase_q <= 1'b1;
    end
    else if (phase_q)
    begin
      phase_q <= 1'b0;
      sum_q <= sum_q + `SUM_W'(new_q) - (filled_q ? `SUM_W'(old_q) : '0);
      if (ptr_q == PTR_W'(WIN_DEPTH - 1))
      begin
        ptr_q <= '0;
        filled_q <= 1'b1;
      end
      else
      begin
        ptr_q <= ptr_q + PTR_W'(1);
      end
    end
  end

  // ****
  // Average every period
  // ****
  assign sum_mag = sum_q[`SUM_W-1] ? `SUM_W'(-sum_q) : `SUM_W'(sum_q);

  seq_divider #(.WIDTH(`SUM_W)) u_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(avg_tick),
    .dividend_in(sum_mag),
    .divisor_in(`SUM_W'(WIN_DEPTH)),
    .done_out(div_done),
    .quotient_out(quot)
  );

  // Latch sign at start, publish on completion
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sum_neg_q <= 1'b0;
      avg_current_out <= '0;
    end
    else
    begin
      if (avg_tick)
      begin
        sum_neg_q <= sum_q[`SUM_W-1];
      end
      if (div_done)
      begin
        avg_current_out <= sum_neg_q ? -`CUR_W'(quot) : `CUR_W'(quot);
      end
    end
  end

  assign avg_mag = avg_current_out[`CUR_W-1] ? `CUR_W'(-avg_current_out) : avg_current_out;
  assign avg_over = avg_mag > avg_limit_in;

  // ****
  // Position error protection
  // ****
  assign err_mag = pos_err_in[`WORD_W-1] ? (`WORD_W+1)'(-{pos_err_in[`WORD_W-1], pos_err_in})
                                         : {1'b0, pos_err_in};
  assign pos_trip = (max_position_error_cfg_in != '0) &&
                    (err_mag > {1'b0, max_position_error_cfg_in});

  // Sticky shutdown, a new trip beats the clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      amp_shutdown_out <= 1'b0;
      error_code_out <= 8'h0;
    end
    else if (pos_trip)
    begin
      amp_shutdown_out <= 1'b1;
      error_code_out <= `POS_ERR_CODE;
    end
    else if (fault_clear_in)
    begin
      amp_shutdown_out <= 1'b0;
      error_code_out <= 8'h0;
    end
  end

  // ****
  // Status words
  // ****
  always_comb
  begin
    drv_word = '0;
    drv_word[`DRV_BIT_ENABLE] = drv_flags_in.enable_disabled;
    drv_word[`DRV_BIT_CRC] = drv_flags_in.crc_failed;
    drv_word[`DRV_BIT_AVG] = avg_over;
    drv_word[`DRV_BIT_POSERR] = amp_shutdown_out;
    drv_word[`DRV_BIT_PWM] = drv_flags_in.pwm_shutdown;
    drv_word[`DRV_BIT_OVERCUR] = drv_flags_in.overcurrent_shutdown;
    drv_word[`DRV_BIT_ECHO] = drv_flags_in.echo_off;
  end

  // Field order of the struct gives bits 23..0
  assign idx_word = {{(`WORD_W-`IDX_USED_BITS){1'b0}}, idx_flags_in};

  // Registered copies for readers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      drive_status_word_out <= '0;
      indexer_status_word_out <= '0;
    end
    else
    begin
      drive_status_word_out <= drv_word;
      indexer_status_word_out <= idx_word;
    end
  end

  // ****
  // Peak hold
  // ****
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      peak_current_out <= '0;
    end
    else if (cmd_valid_in && cmd_code_in == monitor_pkg::report_peak_current)
    begin
      peak_current_out <= cur_sample_in;
    end
    else if (peak_tick && cur_sample_in > peak_current_out)
    begin
      peak_current_out <= cur_sample_in;
    end
  end

  // ****
  // Report mode
  // ****
  assign line_start = (gen_q == gen_idle) && (mode_q != monitor_pkg::cmd_none);

  // New request wins, any character stops repeats
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_q <= monitor_pkg::cmd_none;
    end
    else if (cmd_valid_in)
    begin
      mode_q <= cmd_code_in;
    end
    else if (char_rx_in)
    begin
      mode_q <= monitor_pkg::cmd_none;
    end
    else if (line_start && (mode_q == monitor_pkg::report_drive_flags ||
                            mode_q == monitor_pkg::report_indexer_flags))
    begin
      mode_q <= monitor_pkg::cmd_none;
    end
  end

  // ****
  // Line generator
  // ****
  always_comb
  begin
    case (mode_q)
      monitor_pkg::report_average_current: pick_val = avg_current_out;
      monitor_pkg::report_peak_current: pick_val = peak_current_out;
      default: pick_val = cur_sample_in;
    endcase
    pick_mag = pick_val[`CUR_W-1] ? (`CUR_W+1)'(-{pick_val[`CUR_W-1], pick_val})
                                  : {1'b0, pick_val};
  end

  assign adv = gen_valid && (!tx_valid_q || tx_ready_in);

  // Sequencing of prefix, number, suffix and bit lines
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      gen_q <= gen_idle;
      idx_q <= 6'h0;
      kind_q <= monitor_pkg::cmd_none;
      word_q <= '0;
      neg_q <= 1'b0;
      bcd_q <= 20'h0;
    end
    else
    begin
      case (gen_q)
        gen_idle:
        begin
          if (line_start)
          begin
            kind_q <= mode_q;
            idx_q <= 6'h0;
            neg_q <= pick_val[`CUR_W-1];
            bcd_q <= to_bcd(pick_mag[15:0]);
            word_q <= (mode_q == monitor_pkg::report_drive_flags) ? drv_word : idx_word;
            if (mode_q == monitor_pkg::report_drive_flags ||
                mode_q == monitor_pkg::report_indexer_flags)
            begin
              gen_q <= gen_bits;
            end
            else
            begin
              gen_q <= gen_prefix;
            end
          end
        end
        gen_prefix:
        begin
          if (adv)
          begin
            if (idx_q == ((kind_q == monitor_pkg::report_average_current) ? 6'h10 : 6'h08))
            begin
              gen_q <= gen_number;
              idx_q <= 6'h0;
            end
            else
            begin
              idx_q <= idx_q + 6'h1;
            end
          end
        end
        gen_number:
        begin
          if (adv)
          begin
            idx_q <= (idx_q == `NUM_LAST) ? 6'h0 : idx_q + 6'h1;
            gen_q <= (idx_q == `NUM_LAST) ? gen_suffix : gen_number;
          end
        end
        gen_suffix:
        begin
          if (adv)
          begin
            idx_q <= idx_q + 6'h1;
            gen_q <= (idx_q == `SUFFIX_LAST) ? gen_idle : gen_suffix;
          end
        end
        gen_bits:
        begin
          if (adv)
          begin
            idx_q <= idx_q + 6'h1;
            gen_q <= (idx_q == `BITS_LAST) ? gen_idle : gen_bits;
          end
        end
        default: gen_q <= gen_idle;
      endcase
    end
  end

  // Character for the current position
  always_comb
  begin
    int p;
    int pos;
    p = int'(idx_q) - 1;
    pos = `WORD_W - 1 - ((p / 5) * 4 + (p % 5));
    gen_valid = (gen_q != gen_idle);
    gen_char = 8'h00;
    case (gen_q)
      gen_prefix:
      begin
        if (kind_q == monitor_pkg::report_average_current)
        begin
          gen_char = AVG_TXT[8 * (16 - int'(idx_q)) +: 8];
        end
        else
        begin
          gen_char = CUR_TXT[8 * (8 - int'(idx_q)) +: 8];
        end
      end
      gen_number:
      begin
        case (idx_q)
          6'h00: gen_char = neg_q ? `CHAR_MINUS : `CHAR_PLUS;
          6'h01: gen_char = {`CHAR_ZERO_HI, bcd_q[19:16]};
          6'h02: gen_char = {`CHAR_ZERO_HI, bcd_q[15:12]};
          6'h03: gen_char = {`CHAR_ZERO_HI, bcd_q[11:8]};
          6'h04: gen_char = `CHAR_DOT;
          6'h05: gen_char = {`CHAR_ZERO_HI, bcd_q[7:4]};
          default: gen_char = {`CHAR_ZERO_HI, bcd_q[3:0]};
        endcase
      end
      gen_suffix:
      begin
        gen_char = (idx_q == `SUFFIX_LAST) ? `CHAR_CR : SFX_TXT[8 * (7 - int'(idx_q)) +: 8];
      end
      gen_bits:
      begin
        if (idx_q == 6'h0)
        begin
          gen_char = `CHAR_STAR;
        end
        else if (idx_q == `BITS_LAST)
        begin
          gen_char = `CHAR_CR;
        end
        else if (p % 5 == 4)
        begin
          gen_char = `CHAR_USCORE;
        end
        else
        begin
          gen_char = {7'h18, word_q[pos]};
        end
      end
      default: gen_char = 8'h00;
    endcase
  end

  // ****
  // Output register
  // ****
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
    end
    else if (adv)
    begin
      tx_valid_q <= 1'b1;
      tx_data_q <= gen_char;
    end
    else if (tx_ready_in)
    begin
      tx_valid_q <= 1'b0;
    end
  end

  assign tx_valid_out = tx_valid_q;
  assign tx_data_out = tx_data_q;
  assign report_busy_out = (gen_q != gen_idle) || tx_valid_q;

endmodule : drive_status_current_monitor

`default_nettype wire

// *** bench/host_link_model.sv ***
// Host end of the serial report link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  input wire logic clk_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  input wire logic slow_in,
  output logic ready_out,
  output logic [383:0] line_out,
  output int lines_out
);
  // ****
  // Receiver
  // ****
  logic [383:0] acc_q;
  // Idle until the first edge
  initial
  begin
    ready_out = 1'b0;
    acc_q = '0;
    line_out = '0;
    lines_out = 0;
  end
  // Line gatherer, slow mode stalls alternate cycles
  always @(posedge clk_in)
  begin
    if (valid_in && ready_out)
    begin
      if (data_in == 8'h0d)
      begin
        line_out <= acc_q;
        acc_q <= '0;
        lines_out <= lines_out + 1;
      end
      else
        acc_q <= {acc_q[375:0], data_in};
    end
    ready_out <= slow_in ? !ready_out : 1'b1;
  end
endmodule : host_link_model
`default_nettype wire

// *** bench/drive_status_current_monitor_checker.sv ***
// Port assertions of the status and current monitor
`timescale 1ns/1ps
`default_nettype none
module drive_status_current_monitor_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire monitor_pkg::cmd_e cmd_code_in,
  input wire logic char_rx_in,
  input wire logic tx_ready_in,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire monitor_pkg::drive_flags_s drv_flags_in,
  input wire monitor_pkg::indexer_flags_s idx_flags_in,
  input wire logic signed [31:0] pos_err_in,
  input wire logic [31:0] max_position_error_cfg_in,
  input wire logic fault_clear_in,
  input wire logic amp_shutdown_out,
  input wire logic [7:0] error_code_out,
  input wire logic [31:0] drive_status_word_out,
  input wire logic [31:0] indexer_status_word_out,
  input wire logic report_busy_out
);
  // ****
  // Helpers
  // ****
  logic [1:0] up_q;
  logic stop_q;
  logic [31:0] err_mag;
  // Edges since reset, saturating
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end
  // Stop character seen since the last request
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      stop_q <= 1'b0;
    else if (cmd_valid_in)
      stop_q <= 1'b0;
    else if (char_rx_in)
      stop_q <= 1'b1;
  end
  assign err_mag = pos_err_in[31] ? 32'h0 - pos_err_in : pos_err_in;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // ****
  // Properties
  // ****
  sequence s_req;
    stop_q && cmd_valid_in && cmd_code_in != monitor_pkg::cmd_none && !report_busy_out
      && !tx_valid_out;
  endsequence
  sequence s_star;
    tx_valid_out && tx_data_out == 8'h2a;
  endsequence
  sequence s_last;
    stop_q && tx_valid_out && tx_ready_in && tx_data_out == 8'h0d && !cmd_valid_in;
  endsequence
  property p_answer;
    s_req |-> ##3 s_star;
  endproperty
  a_answer: assert property (p_answer) else $error("line did not open");
  property p_stop;
    s_last |=> !tx_valid_out [*2];
  endproperty
  a_stop: assert property (p_stop) else $error("line after stop");
  property p_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("character dropped");
  property p_code;
    error_code_out == (amp_shutdown_out ? 8'h14 : 8'h00);
  endproperty
  a_code: assert property (p_code) else $error("fault code wrong");
  property p_trip;
    max_position_error_cfg_in != 0 && err_mag > max_position_error_cfg_in |=> amp_shutdown_out;
  endproperty
  a_trip: assert property (p_trip) else $error("no shutdown");
  property p_off;
    max_position_error_cfg_in == 0 && !amp_shutdown_out |=> !amp_shutdown_out;
  endproperty
  a_off: assert property (p_off) else $error("shutdown while off");
  property p_sticky;
    amp_shutdown_out && !fault_clear_in |=> amp_shutdown_out;
  endproperty
  a_sticky: assert property (p_sticky) else $error("shutdown lost");
  property p_drv;
    up_q == 2'h3 |-> {drive_status_word_out[11], drive_status_word_out[8],
      drive_status_word_out[3], drive_status_word_out[1:0], drive_status_word_out[5]}
      == $past({drv_flags_in, amp_shutdown_out});
  endproperty
  a_drv: assert property (p_drv) else $error("drive word bits");
  property p_idx;
    up_q == 2'h3 |-> indexer_status_word_out == {8'h00, $past(idx_flags_in)};
  endproperty
  a_idx: assert property (p_idx) else $error("indexer word");
  property p_rsv;
    (drive_status_word_out & 32'hfffff694) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
endmodule : drive_status_current_monitor_checker
`default_nettype wire

// *** bench/drive_status_current_monitor_tb_top.sv ***
// Self-checking bench of the status and current monitor
`timescale 1ns/1ps
`default_nettype none
module drive_status_current_monitor_tb_top;
  // ****
  // Stimulus and hookup
  // ****
  logic clk_in, rst_in, cmd_valid_in, char_rx_in, tx_ready_in, tx_valid_out, fault_clear_in;
  logic amp_shutdown_out, report_busy_out, slow;
  monitor_pkg::cmd_e cmd_code_in;
  logic [7:0] tx_data_out, error_code_out;
  logic signed [15:0] cur_sample_in, avg_current_out, peak_current_out;
  logic [15:0] avg_limit_in;
  monitor_pkg::drive_flags_s drv_flags_in;
  monitor_pkg::indexer_flags_s idx_flags_in;
  logic signed [31:0] pos_err_in;
  logic [31:0] max_position_error_cfg_in, drive_status_word_out, indexer_status_word_out;
  logic [383:0] line;
  int lines, bad_count, compares;
  drive_status_current_monitor #(.WIN_DEPTH(8), .WIN_PERIOD_CYC(4), .AVG_PERIOD_CYC(64),
    .PEAK_PERIOD_CYC(5)) u_dut (.clk_in, .rst_in, .cmd_valid_in, .cmd_code_in, .char_rx_in,
    .tx_ready_in, .tx_valid_out, .tx_data_out, .cur_sample_in, .avg_limit_in, .drv_flags_in,
    .idx_flags_in, .pos_err_in, .max_position_error_cfg_in, .fault_clear_in, .amp_shutdown_out,
    .error_code_out, .avg_current_out, .peak_current_out, .drive_status_word_out,
    .indexer_status_word_out, .report_busy_out);
  host_link_model u_host (.clk_in, .valid_in(tx_valid_out), .data_in(tx_data_out),
    .slow_in(slow), .ready_out(tx_ready_in), .line_out(line), .lines_out(lines));
  // Clock
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [383:0] seen, input logic [383:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic send(input monitor_pkg::cmd_e c);
    cmd_code_in = c;
    cmd_valid_in = 1'b1;
    tick(1);
    cmd_valid_in = 1'b0;
  endtask : send
  task automatic halt();
    char_rx_in = 1'b1;
    tick(1);
    char_rx_in = 1'b0;
    tick(60);
  endtask : halt
  task automatic wait_line();
    int n;
    n = lines;
    for (int k = 0; k < 400 && lines == n; k++)
      tick(1);
    check("line wait", lines != n, 1'b1);
  endtask : wait_line
  // Expected flag line
  function automatic logic [383:0] fmt(input logic [31:0] w);
    logic [383:0] s;
    s = 384'h2a;
    for (int i = 31; i >= 0; i--)
    begin
      s = {s[375:0], w[i] ? 8'h31 : 8'h30};
      if (i % 4 == 0 && i != 0)
        s = {s[375:0], 8'h5f};
    end
    return s;
  endfunction : fmt
  // ****
  // Scenarios
  // ****
  task automatic t_avg();
    int n;
    tick(300);
    check("avg", avg_current_out, 16'sd283);
    check("avg flag", drive_status_word_out[6], 1'b1);
    send(monitor_pkg::report_average_current);
    wait_line();
    check("avg line", line, "*AVERAGE_CURRENT=+002.83_AMPERES");
    halt();
    n = lines;
    tick(100);
    check("stopped", lines, n);
    cur_sample_in = -16'sd117;
    tick(300);
    check("window", avg_current_out, -16'sd117);
    $display("test avg done");
  endtask : t_avg
  task automatic t_inst();
    cur_sample_in = -16'sd150;
    send(monitor_pkg::report_instant_current);
    wait_line();
    check("inst", line, "*CURRENT=-001.50_AMPERES");
    cur_sample_in = 16'sd7;
    wait_line();
    wait_line();
    check("inst again", line, "*CURRENT=+000.07_AMPERES");
    halt();
    $display("test inst done");
  endtask : t_inst
  task automatic t_peak();
    cur_sample_in = 16'sd50;
    send(monitor_pkg::report_peak_current);
    tick(3);
    cur_sample_in = 16'sd200;
    tick(12);
    cur_sample_in = 16'sd100;
    tick(20);
    check("peak", peak_current_out, 16'sd200);
    wait_line();
    wait_line();
    check("peak line", line, "*CURRENT=+002.00_AMPERES");
    cur_sample_in = 16'sd30;
    send(monitor_pkg::report_peak_current);
    tick(3);
    check("peak restart", peak_current_out, 16'sd30);
    cur_sample_in = 16'sd20;
    tick(20);
    check("peak kept", peak_current_out, 16'sd30);
    halt();
    $display("test peak done");
  endtask : t_peak
  task automatic t_flags();
    avg_limit_in = 16'h012c;
    drv_flags_in = 5'b10101;
    idx_flags_in = 24'hc35a96;
    send(monitor_pkg::report_drive_flags);
    wait_line();
    check("drive line", line, fmt(32'h809));
    slow = 1'b1;
    drv_flags_in = 5'b01010;
    send(monitor_pkg::report_drive_flags);
    wait_line();
    check("drive line 2", line, fmt(32'h102));
    send(monitor_pkg::report_indexer_flags);
    wait_line();
    check("idx line", line, fmt(32'hc35a96));
    slow = 1'b0;
    $display("test flags done");
  endtask : t_flags
  task automatic t_pos();
    pos_err_in = 32'sh7fff0000;
    tick(5);
    check("off", amp_shutdown_out, 1'b0);
    max_position_error_cfg_in = 32'h64;
    pos_err_in = 32'sd100;
    tick(3);
    check("equal", amp_shutdown_out, 1'b0);
    pos_err_in = -32'sd101;
    tick(3);
    check("trip", amp_shutdown_out, 1'b1);
    check("code", error_code_out, 8'h14);
    check("bit5", drive_status_word_out[5], 1'b1);
    pos_err_in = 32'sd0;
    fault_clear_in = 1'b1;
    tick(1);
    fault_clear_in = 1'b0;
    tick(2);
    check("clear", amp_shutdown_out, 1'b0);
    $display("test pos done");
  endtask : t_pos
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial
  begin
    {rst_in, cmd_valid_in, char_rx_in, fault_clear_in, slow} = 5'b10000;
    cmd_code_in = monitor_pkg::cmd_none;
    cur_sample_in = 16'sd283;
    avg_limit_in = 16'h0064;
    drv_flags_in = '0;
    idx_flags_in = '0;
    pos_err_in = '0;
    max_position_error_cfg_in = '0;
    tick(12);
    rst_in = 1'b0;
    t_avg();
    t_inst();
    t_peak();
    t_flags();
    t_pos();
    give_verdict();
  end
  // Watchdog
  initial
  begin
    #80000;
    bad_count++;
    give_verdict();
  end
endmodule : drive_status_current_monitor_tb_top
bind drive_status_current_monitor drive_status_current_monitor_checker u_chk (.clk_in, .rst_in,
  .cmd_valid_in, .cmd_code_in, .char_rx_in, .tx_ready_in, .tx_valid_out, .tx_data_out,
  .drv_flags_in, .idx_flags_in, .pos_err_in, .max_position_error_cfg_in, .fault_clear_in,
  .amp_shutdown_out, .error_code_out, .drive_status_word_out, .indexer_status_word_out,
  .report_busy_out);
`default_nettype wire
